// ### verilog/uart_defs.svh
`ifndef UART_DEFS_SVH
`define UART_DEFS_SVH

// clock
`define CLK_HZ_DEF      10_000_000
`define CLK_PERIOD_NS   100

// register byte offsets
`define OFF_TX_CFG      8'h00
`define OFF_RX_CFG      8'h04
`define OFF_CTRL        8'h08
`define OFF_TX_DATA     8'h0C
`define OFF_RX_DATA     8'h10
`define OFF_STATUS      8'h14
`define OFF_MASK        8'h18

// reset values: 110 bit/s, 7 bits, 2 stop bits, even parity
`define TX_CFG_RST      9'h0E0
`define RX_CFG_RST      9'h0E0
`define CTRL_RST        1'b0
`define MASK_RST        5'h00

// ctrl and status fields
`define CTRL_MODE_BIT   0
`define STS_TX_DONE     0
`define STS_RX_READY    1
`define STS_PAR_ERR     2
`define STS_FRAME_ERR   3
`define STS_OVERRUN     4
`define STS_W           5

// selectable baud rates, bit/s
`define BAUD_R0         110
`define BAUD_R1         150
`define BAUD_R2         300
`define BAUD_R3         600
`define BAUD_R4         1200
`define BAUD_R5         2400
`define BAUD_R6         4800
`define BAUD_R7         9600
`define BAUD_R8         19200
`define BAUD_R9         38400

// data length code 0..3 means 5..8 bits
`define LEN_BASE        3'h4

`endif

// ### verilog/uart_pkg.sv
package uart_pkg;

  typedef enum logic [1:0] {
    PAR_NONE = 2'h0,
    PAR_EVEN = 2'h1,
    PAR_ODD  = 2'h2
  } parity_e;

  // layout of the tx and rx configuration registers
  typedef struct packed {
    parity_e    parity;
    logic       stop2;
    logic [1:0] len;
    logic [3:0] baud;
  } chan_cfg_s;

  typedef enum logic [4:0] {
    TX_IDLE  = 5'b00001,
    TX_START = 5'b00010,
    TX_DATA  = 5'b00100,
    TX_PAR   = 5'b01000,
    TX_STOP  = 5'b10000
  } tx_state_e;

  typedef enum logic [4:0] {
    RX_IDLE  = 5'b00001,
    RX_START = 5'b00010,
    RX_DATA  = 5'b00100,
    RX_PAR   = 5'b01000,
    RX_STOP  = 5'b10000
  } rx_state_e;

endpackage : uart_pkg

// ### verilog/overhead_overhead_char_channel_mode_char_link.sv
// Chosen here: the AHB-Lite register port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "uart_defs.svh"

module overhead_overhead_char_channel_mode_char_link #(
  parameter int unsigned CLK_HZ = `CLK_HZ_DEF
) (
  // clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        reset_n_in,
  // ahb-lite slave
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic        hready_in,
  input  wire logic [31:0] hwdata_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  // option hardware, serial line, interrupt
  input  wire logic        option_fitted_in,
  input  wire logic        rx_in,
  output logic             tx_out,
  output logic             irq_out
);
  import uart_pkg::*;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [16:0] baud_div(input logic [3:0] idx);
    int unsigned r;
    case (idx)
      4'h1:    r = `BAUD_R1;
      4'h2:    r = `BAUD_R2;
      4'h3:    r = `BAUD_R3;
      4'h4:    r = `BAUD_R4;
      4'h5:    r = `BAUD_R5;
      4'h6:    r = `BAUD_R6;
      4'h7:    r = `BAUD_R7;
      4'h8:    r = `BAUD_R8;
      4'h9:    r = `BAUD_R9;
      default: r = `BAUD_R0;
    endcase
    return 17'(CLK_HZ / r);
  endfunction : baud_div

  function automatic logic [7:0] len_mask(input logic [1:0] len);
    return 8'(8'hFF >> (2'd3 - len));
  endfunction : len_mask

  // ****************************************************************
  // declarations
  // ****************************************************************
  chan_cfg_s          tx_cfg_q, tx_cfg_d, rx_cfg_q, rx_cfg_d;
  logic               mode_q, mode_d, wr_q, wr_d, irq_q, irq_d;
  logic [7:0]         addr_q, addr_d, rx_data_q, rx_data_d;
  logic [`STS_W-1:0]  sts_q, sts_d, mask_q, mask_d;
  logic [31:0]        rdata_q, rdata_d;
  logic               active, take, tx_load;
  tx_state_e          tx_st_q, tx_st_d;
  logic [16:0]        tx_cnt_q, tx_cnt_d, tx_div;
  logic [2:0]         tx_idx_q, tx_idx_d, tx_last;
  logic [7:0]         tx_sh_q, tx_sh_d;
  logic               tx_par_q, tx_par_d, tx_stp_q, tx_stp_d;
  logic               tx_line_q, tx_line_d, tx_tick, tx_done_evt;
  rx_state_e          rx_st_q, rx_st_d;
  logic [16:0]        rx_cnt_q, rx_cnt_d, rx_div;
  logic [2:0]         rx_idx_q, rx_idx_d, rx_last;
  logic [7:0]         rx_sh_q, rx_sh_d;
  logic               rx_par_q, rx_par_d, rx_stp_q, rx_stp_d, rx_tick;
  logic               rx_done_evt, rx_pe_evt, rx_fe_evt;

  assign active = mode_q && option_fitted_in;

  // ****************************************************************
  // bus slave, registers and interrupt
  // ****************************************************************
  always_comb
  begin
    take      = hsel_in && htrans_in[1] && hready_in;
    tx_cfg_d  = tx_cfg_q;
    rx_cfg_d  = rx_cfg_q;
    mode_d    = mode_q;
    mask_d    = mask_q;
    sts_d     = sts_q;
    wr_d      = take && hwrite_in;
    addr_d    = take ? haddr_in[7:0] : addr_q;
    rdata_d   = 32'h0;
    // data phase of a write
    if (wr_q)
    begin
      if (addr_q == `OFF_TX_CFG)
        tx_cfg_d = chan_cfg_s'(hwdata_in[8:0]);
      else if (addr_q == `OFF_RX_CFG)
        rx_cfg_d = chan_cfg_s'(hwdata_in[8:0]);
      else if (addr_q == `OFF_CTRL)
        mode_d = hwdata_in[`CTRL_MODE_BIT];
      else if (addr_q == `OFF_MASK)
        mask_d = hwdata_in[`STS_W-1:0];
    end
    // read data is prepared at the address phase
    if (take && !hwrite_in)
    begin
      if (haddr_in[7:0] == `OFF_TX_CFG)
        rdata_d[8:0] = tx_cfg_q;
      else if (haddr_in[7:0] == `OFF_RX_CFG)
        rdata_d[8:0] = rx_cfg_q;
      else if (haddr_in[7:0] == `OFF_CTRL)
        rdata_d[0] = mode_q;
      else if (haddr_in[7:0] == `OFF_RX_DATA)
        rdata_d[7:0] = rx_data_q;
      else if (haddr_in[7:0] == `OFF_STATUS)
      begin
        rdata_d = {22'h0, active, (tx_st_q != TX_IDLE), 3'h0, sts_q};
        sts_d   = '0;
      end
      else if (haddr_in[7:0] == `OFF_MASK)
        rdata_d[`STS_W-1:0] = mask_q;
    end
    // new events win over the read clear
    sts_d[`STS_TX_DONE]   = sts_d[`STS_TX_DONE] | tx_done_evt;
    sts_d[`STS_RX_READY]  = sts_d[`STS_RX_READY] | rx_done_evt;
    sts_d[`STS_PAR_ERR]   = sts_d[`STS_PAR_ERR] | rx_pe_evt;
    sts_d[`STS_FRAME_ERR] = sts_d[`STS_FRAME_ERR] | rx_fe_evt;
    sts_d[`STS_OVERRUN]   = sts_d[`STS_OVERRUN]
                            | (rx_done_evt && sts_q[`STS_RX_READY]);
    irq_d = |(sts_q & mask_q);
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!reset_n_in)
    begin
      tx_cfg_q <= chan_cfg_s'(`TX_CFG_RST);
      rx_cfg_q <= chan_cfg_s'(`RX_CFG_RST);
      mode_q   <= `CTRL_RST;
      mask_q   <= `MASK_RST;
      sts_q    <= '0;
      wr_q     <= 1'b0;
      addr_q   <= 8'h00;
      rdata_q  <= 32'h0;
      irq_q    <= 1'b0;
    end
    else
    begin
      tx_cfg_q <= tx_cfg_d;
      rx_cfg_q <= rx_cfg_d;
      mode_q   <= mode_d;
      mask_q   <= mask_d;
      sts_q    <= sts_d;
      wr_q     <= wr_d;
      addr_q   <= addr_d;
      rdata_q  <= rdata_d;
      irq_q    <= irq_d;
    end
  end

  assign hrdata_out    = rdata_q;
  assign hreadyout_out = 1'b1;
  assign hresp_out     = 1'b0;
  assign irq_out       = irq_q;

  // ****************************************************************
  // transmitter
  // ****************************************************************
  always_comb
  begin
    tx_div      = baud_div(tx_cfg_q.baud);
    tx_last     = 3'(tx_cfg_q.len) + `LEN_BASE;
    tx_load     = wr_q && (addr_q == `OFF_TX_DATA) && active
                  && (tx_st_q == TX_IDLE);
    tx_tick     = (tx_cnt_q == 17'h0);
    tx_st_d     = tx_st_q;
    tx_cnt_d    = tx_tick ? tx_cnt_q : tx_cnt_q - 17'h1;
    tx_idx_d    = tx_idx_q;
    tx_sh_d     = tx_sh_q;
    tx_par_d    = tx_par_q;
    tx_stp_d    = tx_stp_q;
    tx_done_evt = 1'b0;
    if (!active)
      tx_st_d = TX_IDLE;
    else
      case (tx_st_q)
        TX_IDLE:
          if (tx_load)
          begin
            tx_st_d  = TX_START;
            tx_cnt_d = tx_div - 17'h1;
            tx_sh_d  = hwdata_in[7:0];
            tx_par_d = (^(hwdata_in[7:0] & len_mask(tx_cfg_q.len)))
                       ^ (tx_cfg_q.parity == PAR_ODD);
            tx_idx_d = 3'h0;
            tx_stp_d = 1'b0;
          end
        TX_START:
          if (tx_tick)
          begin
            tx_st_d  = TX_DATA;
            tx_cnt_d = tx_div - 17'h1;
          end
        TX_DATA:
          if (tx_tick)
          begin
            tx_cnt_d = tx_div - 17'h1;
            tx_sh_d  = tx_sh_q >> 1;
            tx_idx_d = tx_idx_q + 3'h1;
            if (tx_idx_q == tx_last)
              tx_st_d = (tx_cfg_q.parity == PAR_EVEN
                         || tx_cfg_q.parity == PAR_ODD) ? TX_PAR : TX_STOP;
          end
        TX_PAR:
          if (tx_tick)
          begin
            tx_st_d  = TX_STOP;
            tx_cnt_d = tx_div - 17'h1;
          end
        TX_STOP:
          if (tx_tick)
          begin
            if (tx_cfg_q.stop2 && !tx_stp_q)
            begin
              tx_stp_d = 1'b1;
              tx_cnt_d = tx_div - 17'h1;
            end
            else
            begin
              tx_st_d     = TX_IDLE;
              tx_done_evt = 1'b1;
            end
          end
        default:
          tx_st_d = TX_IDLE;
      endcase
    case (tx_st_d)
      TX_START: tx_line_d = 1'b0;
      TX_DATA:  tx_line_d = tx_sh_d[0];
      TX_PAR:   tx_line_d = tx_par_d;
      default:  tx_line_d = 1'b1;
    endcase
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!reset_n_in)
    begin
      tx_st_q   <= TX_IDLE;
      tx_cnt_q  <= 17'h0;
      tx_idx_q  <= 3'h0;
      tx_sh_q   <= 8'h00;
      tx_par_q  <= 1'b0;
      tx_stp_q  <= 1'b0;
      tx_line_q <= 1'b1;
    end
    else
    begin
      tx_st_q   <= tx_st_d;
      tx_cnt_q  <= tx_cnt_d;
      tx_idx_q  <= tx_idx_d;
      tx_sh_q   <= tx_sh_d;
      tx_par_q  <= tx_par_d;
      tx_stp_q  <= tx_stp_d;
      tx_line_q <= tx_line_d;
    end
  end

  assign tx_out = tx_line_q;

  // ****************************************************************
  // receiver
  // ****************************************************************
  always_comb
  begin
    rx_div      = baud_div(rx_cfg_q.baud);
    rx_last     = 3'(rx_cfg_q.len) + `LEN_BASE;
    rx_tick     = (rx_cnt_q == 17'h0);
    rx_st_d     = rx_st_q;
    rx_cnt_d    = rx_tick ? rx_cnt_q : rx_cnt_q - 17'h1;
    rx_idx_d    = rx_idx_q;
    rx_sh_d     = rx_sh_q;
    rx_par_d    = rx_par_q;
    rx_stp_d    = rx_stp_q;
    rx_data_d   = rx_data_q;
    rx_done_evt = 1'b0;
    rx_pe_evt   = 1'b0;
    rx_fe_evt   = 1'b0;
    if (!active)
      rx_st_d = RX_IDLE;
    else
      case (rx_st_q)
        RX_IDLE:
          if (!rx_in)
          begin
            rx_st_d  = RX_START;
            rx_cnt_d = 17'(rx_div >> 1) - 17'h1;
          end
        RX_START:
          if (rx_tick)
          begin
            rx_st_d  = rx_in ? RX_IDLE : RX_DATA;
            rx_cnt_d = rx_div - 17'h1;
            rx_idx_d = 3'h0;
            rx_sh_d  = 8'h00;
            rx_par_d = 1'b0;
          end
        RX_DATA:
          if (rx_tick)
          begin
            rx_sh_d[rx_idx_q] = rx_in;
            rx_par_d = rx_par_q ^ rx_in;
            rx_cnt_d = rx_div - 17'h1;
            rx_idx_d = rx_idx_q + 3'h1;
            rx_stp_d = 1'b0;
            if (rx_idx_q == rx_last)
              rx_st_d = (rx_cfg_q.parity == PAR_EVEN
                         || rx_cfg_q.parity == PAR_ODD) ? RX_PAR : RX_STOP;
          end
        RX_PAR:
          if (rx_tick)
          begin
            rx_par_d = rx_par_q ^ rx_in;
            rx_cnt_d = rx_div - 17'h1;
            rx_st_d  = RX_STOP;
          end
        RX_STOP:
          if (rx_tick)
          begin
            if (!rx_in)
            begin
              rx_fe_evt = 1'b1;
              rx_st_d   = RX_IDLE;
            end
            else if (rx_cfg_q.stop2 && !rx_stp_q)
            begin
              rx_stp_d = 1'b1;
              rx_cnt_d = rx_div - 17'h1;
            end
            else
            begin
              rx_done_evt = 1'b1;
              rx_data_d   = rx_sh_q;
              rx_pe_evt   = (rx_cfg_q.parity == PAR_EVEN
                             || rx_cfg_q.parity == PAR_ODD)
                            && (rx_par_q
                                != (rx_cfg_q.parity == PAR_ODD));
              rx_st_d     = RX_IDLE;
            end
          end
        default:
          rx_st_d = RX_IDLE;
      endcase
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!reset_n_in)
    begin
      rx_st_q   <= RX_IDLE;
      rx_cnt_q  <= 17'h0;
      rx_idx_q  <= 3'h0;
      rx_sh_q   <= 8'h00;
      rx_par_q  <= 1'b0;
      rx_stp_q  <= 1'b0;
      rx_data_q <= 8'h00;
    end
    else
    begin
      rx_st_q   <= rx_st_d;
      rx_cnt_q  <= rx_cnt_d;
      rx_idx_q  <= rx_idx_d;
      rx_sh_q   <= rx_sh_d;
      rx_par_q  <= rx_par_d;
      rx_stp_q  <= rx_stp_d;
      rx_data_q <= rx_data_d;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!reset_n_in);

  sequence s_rx_fall;
    rx_st_q == RX_IDLE && active && !rx_in;
  endsequence
  sequence s_rx_half;
    rx_st_q == RX_START && rx_cnt_q == 17'(rx_div >> 1) - 17'h1;
  endsequence

  chk_rx_centre_wait: assert property (s_rx_fall |=> s_rx_half)
    else $error("rx start wait is not half a bit");
  chk_tx_off_idle: assert property (!active
    |=> tx_out && tx_st_q == TX_IDLE)
    else $error("tx line not idle while channel inactive");
  chk_tx_start_low: assert property (tx_st_q == TX_START |-> !tx_out)
    else $error("start bit not low");
  chk_tx_stop_high: assert property (tx_st_q == TX_STOP |-> tx_out)
    else $error("stop bit not high");
  chk_tx_bit_hold: assert property (active && tx_st_q != TX_IDLE
    && !tx_tick |=> $stable(tx_out) && $stable(tx_st_q))
    else $error("tx bit changed before its time");
  chk_tx_par_sel: assert property (tx_st_q == TX_PAR
    |-> tx_out == tx_par_q && tx_cfg_q.parity inside {PAR_EVEN, PAR_ODD})
    else $error("tx parity bit wrong");
  chk_tx_data_len: assert property (active && tx_st_q == TX_DATA
    && tx_tick && tx_idx_q == tx_last |=> tx_st_q inside {TX_PAR, TX_STOP})
    else $error("tx data length wrong");
  chk_rx_data_len: assert property (active && rx_st_q == RX_DATA
    && rx_tick && rx_idx_q == rx_last |=> rx_st_q inside {RX_PAR, RX_STOP})
    else $error("rx data length wrong");
  chk_rx_frame_flag: assert property (active && rx_st_q == RX_STOP
    && rx_tick && !rx_in |=> sts_q[`STS_FRAME_ERR] && rx_st_q == RX_IDLE)
    else $error("framing error not flagged");
  chk_irq_level: assert property (##1 1 |-> irq_out == $past(|(sts_q & mask_q)))
    else $error("irq does not follow masked status");

endmodule : overhead_overhead_char_channel_mode_char_link
`default_nettype wire

// ### dv/serial_term_model.sv
`timescale 1ns/10ps
`default_nettype none

module serial_term_model (
  // clock
  input  wire logic sys_clk_in,
  // serial lines
  input  wire logic line_in,
  output logic      line_out
);

  initial line_out = 1'b1;

  // ****************************************
  // one bit time on the line
  // ****************************************
  task automatic put_bit(input logic v, input int div);
    line_out <= v;
    repeat (div) @(posedge sys_clk_in);
  endtask : put_bit

  // start low, data lsb first, parity, stops
  task automatic send(input int div, input int nbits, input logic [7:0] d,
                      input logic par_en, input logic pbit,
                      input logic stop_lvl, input logic stop2);
    put_bit(1'b0, div);
    for (int i = 0; i < nbits; i++)
    begin
      put_bit(d[i], div);
    end
    if (par_en)
      put_bit(pbit, div);
    // a broken frame spoils only its last stop bit, then the line idles
    put_bit(stop2 ? 1'b1 : stop_lvl, div);
    if (stop2)
      put_bit(stop_lvl, div);
    line_out <= 1'b1;
  endtask : send

  // samples each bit at its centre
  task automatic recv(input int div, input int nbits, input logic par_en,
                      input logic stop2, output logic [7:0] d,
                      output logic p, output logic [1:0] st);
    d  = 8'h00;
    p  = 1'b0;
    st = 2'b11;
    while (line_in !== 1'b0) @(posedge sys_clk_in);
    repeat (div / 2) @(posedge sys_clk_in);
    for (int i = 0; i < nbits; i++)
    begin
      repeat (div) @(posedge sys_clk_in);
      d[i] = line_in;
    end
    if (par_en)
    begin
      repeat (div) @(posedge sys_clk_in);
      p = line_in;
    end
    repeat (div) @(posedge sys_clk_in);
    st[0] = line_in;
    if (stop2)
    begin
      repeat (div) @(posedge sys_clk_in);
      st[1] = line_in;
    end
  endtask : recv

endmodule : serial_term_model

`default_nettype wire

// ### dv/tb_overhead_overhead_char_channel_mode_char_link.sv
`timescale 1ns/10ps
`default_nettype none
`include "uart_defs.svh"

module tb_overhead_overhead_char_channel_mode_char_link;
  import uart_pkg::*;

  localparam int unsigned CLK_HZ = 384000;
  localparam int RATE[10] = '{`BAUD_R0, `BAUD_R1, `BAUD_R2, `BAUD_R3,
    `BAUD_R4, `BAUD_R5, `BAUD_R6, `BAUD_R7, `BAUD_R8, `BAUD_R9};
  localparam logic [7:0] RO_ADR[6] = '{`OFF_TX_CFG, `OFF_RX_CFG, `OFF_CTRL,
    `OFF_MASK, `OFF_STATUS, 8'h1C};
  localparam logic [31:0] RO_EXP[6] = '{32'h0E0, 32'h0E0, 32'h0, 32'h0,
    32'h0, 32'h0};

  logic        sys_clk_in = 1'b0;
  logic        reset_n_in = 1'b0;
  logic        hsel       = 1'b0;
  logic [31:0] haddr      = 32'h0;
  logic [1:0]  htrans     = 2'h0;
  logic        hwrite     = 1'b0;
  logic [31:0] hwdata     = 32'h0;
  logic        option_fit = 1'b1;
  logic [31:0] hrdata, v;
  logic        hready, hresp, rx_line, tx_line, irq, rp;
  logic [7:0]  d, rd_d;
  logic [1:0]  rd_s;
  int          error_cnt = 0, checked = 0, seed = 3, cycles = 0;
  int          n, b, l, s, p, m, e, dv;

  always #50 sys_clk_in = ~sys_clk_in;

  overhead_overhead_char_channel_mode_char_link #(.CLK_HZ(CLK_HZ)) DUT (
    .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
    .hsize_in(3'h2), .hready_in(hready), .hwdata_in(hwdata),
    .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
    .option_fitted_in(option_fit), .rx_in(rx_line), .tx_out(tx_line),
    .irq_out(irq));

  serial_term_model PARTNER (.sys_clk_in(sys_clk_in), .line_in(tx_line),
    .line_out(rx_line));

  // ****************************************
  // checks, bus cycles and expectations
  // ****************************************
  task automatic complete_run();
    $display("mismatches %0d, comparisons %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : complete_run

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h, want %h", $time, got, exp);
    end
  endtask : check_word

  task automatic check_cycles(input int got, input int exp);
    checked++;
    if (got != exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: %0d cycles, want %0d", $time, got, exp);
    end
  endtask : check_cycles

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge sys_clk_in);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= w;
    do @(posedge sys_clk_in); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge sys_clk_in); while (hready !== 1'b1);
    rd = hrdata;
    check_word(hresp, 1'b0);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] x;
    bus(1'b1, a, wd, x);
  endtask : wr

  function automatic int div_of(input int i);
    return CLK_HZ / RATE[i];
  endfunction : div_of

  function automatic logic [7:0] lmask(input int len);
    return 8'hFF >> (3 - len);
  endfunction : lmask

  function automatic logic par_of(input logic [7:0] x, input int len,
                                  input int par);
    return (par == 2) ? ~(^(x & lmask(len))) : ^(x & lmask(len));
  endfunction : par_of

  function automatic logic [31:0] cfg(input int bd, input int len,
                                      input int st, input int par);
    return {23'h0, par[1:0], st[0], len[1:0], bd[3:0]};
  endfunction : cfg

  task automatic draw();
    b = 7 + {$random(seed)} % 3;
    l = {$random(seed)} % 4;
    s = {$random(seed)} % 2;
    p = {$random(seed)} % 3;
    d = 8'($random(seed));
    dv = div_of(b);
  endtask : draw

  always @(posedge sys_clk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      error_cnt++;
      $display("wrong value at %0t: run took too long", $time);
      complete_run();
    end
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    repeat (8) @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    wr(8'h1C, 32'hFFFFFFFF);
    for (int i = 0; i < 6; i++)
    begin
      bus(1'b0, RO_ADR[i], 32'h0, v);
      check_word(v, RO_EXP[i]);
    end
    // option hardware absent: nothing leaves
    option_fit <= 1'b0;
    wr(`OFF_CTRL, 32'h1);
    wr(`OFF_TX_DATA, 32'h00);
    n = 0;
    repeat (40) @(posedge sys_clk_in) n += (tx_line !== 1'b1);
    check_cycles(n, 0);
    bus(1'b0, `OFF_STATUS, 32'h0, v);
    check_word(v, 32'h0);
    option_fit <= 1'b1;
    // start bit width at every rate
    for (int i = 0; i < 10; i++)
    begin
      wr(`OFF_TX_CFG, cfg(i, 3, 0, 0));
      wr(`OFF_TX_DATA, 32'h01);
      n = 0;
      @(posedge sys_clk_in);
      while (tx_line === 1'b0 && n < 5000)
      begin
        n++;
        @(posedge sys_clk_in);
      end
      check_cycles(n, div_of(i));
      // abort inside the low data bits so a stuck line would show
      repeat (div_of(i)) @(posedge sys_clk_in);
      wr(`OFF_CTRL, 32'h0);
      repeat (2) @(posedge sys_clk_in);
      check_word(tx_line, 1'b1);
      wr(`OFF_CTRL, 32'h1);
    end
    wr(`OFF_TX_DATA, 32'h00);
    repeat (5) @(posedge sys_clk_in);
    wr(`OFF_CTRL, 32'h0);
    repeat (2) @(posedge sys_clk_in);
    check_word(tx_line, 1'b1);
    bus(1'b0, `OFF_STATUS, 32'h0, v);
    check_word(v & 32'h300, 32'h0);
    wr(`OFF_CTRL, 32'h1);
    // random transmit frames with interrupt
    repeat (6)
    begin
      draw();
      m = {$random(seed)} % 2;
      bus(1'b0, `OFF_STATUS, 32'h0, v);
      wr(`OFF_MASK, m);
      wr(`OFF_TX_CFG, cfg(b, l, s, p));
      wr(`OFF_TX_DATA, {24'h0, d});
      PARTNER.recv(dv, l + 5, p != 0, s[0], rd_d, rp, rd_s);
      check_word(rd_d, d & lmask(l));
      if (p != 0)
        check_word(rp, par_of(d, l, p));
      check_word(rd_s, 2'b11);
      repeat (dv / 2 - 3) @(posedge sys_clk_in);
      check_word(irq, 1'b0);
      repeat (6) @(posedge sys_clk_in);
      check_word(irq, m[0]);
      bus(1'b0, `OFF_STATUS, 32'h0, v);
      check_word(v & 32'h101, 32'h001);
      repeat (2) @(posedge sys_clk_in);
      check_word(irq, 1'b0);
    end
    // random receive frames, some broken
    repeat (6)
    begin
      draw();
      e = {$random(seed)} % 4;
      wr(`OFF_RX_CFG, cfg(b, l, s, p));
      bus(1'b0, `OFF_STATUS, 32'h0, v);
      PARTNER.send(dv, l + 5, d, p != 0, par_of(d, l, p) ^ (e == 1),
                   e != 2, s[0]);
      repeat (2 * dv) @(posedge sys_clk_in);
      bus(1'b0, `OFF_STATUS, 32'h0, v);
      if (e == 2)
        check_word(v & 32'h3FE, 32'h208);
      else if (e == 1 && p != 0)
        check_word(v & 32'h3FE, 32'h206);
      else
        check_word(v & 32'h3FE, 32'h202);
      bus(1'b0, `OFF_RX_DATA, 32'h0, v);
      if (e != 2)
        check_word(v, d & lmask(l));
    end
    complete_run();
  end

endmodule : tb_overhead_overhead_char_channel_mode_char_link

`default_nettype wire
